// [hw/uvep_pkg.sv]
package uvep_pkg;
    // ==========================================================
    // geometry
    // ==========================================================
    localparam int ADDR_W = 8;       // eight address inputs
    localparam int DATA_W = 8;       // one byte per location
    localparam int DEPTH = 256;      // locations in the part
    // ==========================================================
    // clock and time figures
    // ==========================================================
    localparam int CLK_PS = 4000;            // 250 MHz period in ps
    localparam int ACCESS_NS = 1000;         // slowest access time
    localparam int GATE_SETUP_NS = 400;      // gate supply setup, slowest
    localparam int HOLD_VALID_NS = 5000;     // data stays after gate rises
    localparam int DESELECT_NS = 300;        // outputs float after this
    localparam int INV_ADDR_SETUP_US = 25;   // inverted address setup
    localparam int TRUE_ADDR_SETUP_US = 10;  // true address setup
    localparam int SUPPLY_SETUP_US = 100;    // supplies before pulse
    localparam int PULSE_US = 3000;          // program pulse, max 3 ms
    localparam int DATA_HOLD_US = 10;        // hold after pulse
    localparam int PASSES = 32;              // least number of passes
    // access, gate setup and deselect times round up; the rest, the pulse (a maximum) included, round down
    localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int GATE_SETUP_CYC =
        (GATE_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int DESELECT_CYC = (DESELECT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INV_ADDR_CYC = (INV_ADDR_SETUP_US * 1000000) / CLK_PS;
    localparam int TRUE_ADDR_CYC = (TRUE_ADDR_SETUP_US * 1000000) / CLK_PS;
    localparam int SUPPLY_CYC = (SUPPLY_SETUP_US * 1000000) / CLK_PS;
    // a 3 ms product in ps would not fit a 32-bit int, so scale first
    localparam int PULSE_CYC = PULSE_US * (1000000 / CLK_PS);
    localparam int DATA_HOLD_CYC = (DATA_HOLD_US * 1000000) / CLK_PS;
    localparam int HOLD_VALID_CYC = (HOLD_VALID_NS * 1000) / CLK_PS;
    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;   // high = leave bit zero
endpackage : uvep_pkg

// [hw/uvep_timer.sv]
`timescale 1ns/1ps
// ==============================================================
// down counter: load a count, pulse done once when it expires
// ==============================================================
module uvep_timer #(
    parameter int W = 24
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    logic [W-1:0] cnt_reg;      // remaining cycles
    logic run_reg;              // counting
    wire logic last_w = run_reg && (cnt_reg <= W'(1));
    // counter process
    always_ff @(posedge i_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= last_w;
            if (i_load)
            begin
                cnt_reg <= i_count;
                run_reg <= 1'b1;
            end
            else if (last_w)
                run_reg <= 1'b0;
            else if (run_reg)
                cnt_reg <= cnt_reg - W'(1);
        end
endmodule : uvep_timer

// [hw/uvep_host.sv]
`timescale 1ns/1ps
module uvep_host #(
    parameter int PULSE_CYC = uvep_pkg::PULSE_CYC,
    parameter int SUPPLY_CYC = uvep_pkg::SUPPLY_CYC,
    parameter int INV_CYC = uvep_pkg::INV_ADDR_CYC,
    parameter int TRUE_CYC = uvep_pkg::TRUE_ADDR_CYC,
    parameter int HOLD_CYC = uvep_pkg::DATA_HOLD_CYC,
    parameter int PASSES = uvep_pkg::PASSES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_rd_req,          // read one byte
    input wire logic i_pgm_req,         // program one byte, or sweep all addresses when i_addr is FF and i_wdata 00
    input wire logic i_gate_pulse,      // switched gate supply mode
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,     // ones to be written
    input wire logic [7:0] i_data_pin,  // device outputs
    output logic [7:0] o_addr_pin,      // address lines
    output logic [7:0] o_data_pin,      // programming data lines
    output logic [7:0] o_data_oe_n,     // low while host drives data
    output logic o_cs_n,                // chip select, low active
    output logic o_gate_neg,            // gate supply at negative level
    output logic o_drain_neg,           // pulsed drain supply negative
    output logic o_pgm_pulse,           // program pulse
    output logic o_busy,
    output logic o_rd_valid,            // one-cycle read result strobe
    output logic [7:0] o_rdata,
    output logic o_pgm_done              // one-cycle done strobe, once per single byte or once at the end of a whole sweep
);
    // ==========================================================
    // reset release and elaboration checks
    // ==========================================================
    // refuse zero counts, a pulse count the 24-bit timer cannot hold, or passes the 6-bit pass counter cannot hold
    if (PULSE_CYC < 1 || SUPPLY_CYC < 1 || INV_CYC < 1 || TRUE_CYC < 1 ||
        HOLD_CYC < 1 || PASSES < 1 || PASSES > 64 || PULSE_CYC >= (1 << 24))
    begin : g_bad_cfg
        $error("uvep_host: timing count out of range");
    end
    logic rst1_reg, rst2_reg;   // two-stage reset release
    always_ff @(posedge i_mclk or negedge i_resetn)
        if (!i_resetn)
        begin
            rst1_reg <= 1'b0;
            rst2_reg <= 1'b0;
        end
        else
        begin
            rst1_reg <= 1'b1;
            rst2_reg <= rst1_reg;
        end
    wire logic rstn = rst2_reg;
    // ==========================================================
    // data pin synchroniser, three stages
    // ==========================================================
    logic [7:0] s1_reg, s2_reg, s3_reg, din_reg;
    always_ff @(posedge i_mclk or negedge rstn)
        if (!rstn)
        begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            s3_reg <= 8'h00;
            din_reg <= 8'h00;
        end
        else
        begin
            s1_reg <= i_data_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // take a bit only once stages two and three agree
            din_reg <= (s2_reg & s3_reg) | (din_reg & (s2_reg | s3_reg));
        end
    // ==========================================================
    // state machine
    // ==========================================================
    typedef enum logic [10:0] {
        ST_IDLE = 11'b000_0000_0001,
        ST_RGATE = 11'b000_0000_0010,  // gate low before address
        ST_RACC = 11'b000_0000_0100,   // wait access time
        ST_RDONE = 11'b000_0000_1000,  // capture, gate up in pulsed gate mode
        ST_RDESEL = 11'b000_0001_0000, // wait outputs float
        ST_PINV = 11'b000_0010_0000,   // inverted address setup
        ST_PSUP = 11'b000_0100_0000,   // supplies negative
        ST_PTRUE = 11'b000_1000_0000,  // true address setup
        ST_PPULSE = 11'b001_0000_0000, // program pulse
        ST_PHOLD = 11'b010_0000_0000,  // hold after pulse
        ST_PNEXT = 11'b100_0000_0000   // advance sweep
    } uvep_state_t;
    uvep_state_t st_reg, st_next;
    logic [7:0] adr_reg;      // current target address
    logic [5:0] pass_reg;     // sweep pass count
    logic sweep_reg;          // sweeping all addresses
    logic gate_mode_reg;      // pulsed gate chosen for this read
    logic t_load;             // start timer
    logic [23:0] t_count;
    logic t_done;
    // ==========================================================
    // shared timer
    // ==========================================================
    uvep_timer #(.W(24)) u_timer (
        .i_clk(i_mclk),
        .i_rstn(rstn),
        .i_load(t_load),
        .i_count(t_count),
        .o_done(t_done)
    );
    wire logic sweep_end = (adr_reg == 8'hFF);
    wire logic pass_end = (pass_reg == 6'(PASSES - 1));
    // adr_reg loads on the same edge, so pins use the value it will take
    wire logic sweep_req = (i_addr == 8'hFF) && (i_wdata == 8'h00);
    wire logic [7:0] start_adr = sweep_req ? 8'h00 : i_addr;
    wire logic first_byte = (st_reg == ST_IDLE);
    wire logic [7:0] inv_adr = first_byte ? ~start_adr : ~(adr_reg + 8'h01);
    wire logic [7:0] pgm_dat = (first_byte && !sweep_req) ? ~i_wdata : 8'h00;
    // next state and timer loads
    always_comb
    begin
        st_next = st_reg;
        t_load = 1'b0;
        t_count = 24'h00_0000;
        case (st_reg)
            ST_IDLE:
                if (i_rd_req)
                begin
                    st_next = ST_RGATE;
                    t_load = 1'b1;
                    t_count = 24'(uvep_pkg::GATE_SETUP_CYC);
                end
                else if (i_pgm_req)
                begin
                    st_next = ST_PINV;
                    t_load = 1'b1;
                    t_count = 24'(INV_CYC);
                end
            ST_RGATE:
                if (t_done)
                begin
                    st_next = ST_RACC;
                    t_load = 1'b1;
                    t_count = 24'(uvep_pkg::ACCESS_CYC);
                end
            ST_RACC:
                if (t_done)
                    st_next = ST_RDONE;
            ST_RDONE:
            begin
                st_next = ST_RDESEL;
                t_load = 1'b1;
                t_count = 24'(uvep_pkg::DESELECT_CYC);
            end
            ST_RDESEL:
                if (t_done)
                    st_next = ST_IDLE;
            ST_PINV:
                if (t_done)
                begin
                    st_next = ST_PSUP;
                    t_load = 1'b1;
                    t_count = 24'(SUPPLY_CYC);
                end
            ST_PSUP:
                if (t_done)
                begin
                    st_next = ST_PTRUE;
                    t_load = 1'b1;
                    t_count = 24'(TRUE_CYC);
                end
            ST_PTRUE:
                if (t_done)
                begin
                    st_next = ST_PPULSE;
                    t_load = 1'b1;
                    t_count = 24'(PULSE_CYC);
                end
            ST_PPULSE:
                if (t_done)
                begin
                    st_next = ST_PHOLD;
                    t_load = 1'b1;
                    t_count = 24'(HOLD_CYC);
                end
            ST_PHOLD:
                if (t_done)
                    st_next = ST_PNEXT;
            ST_PNEXT:
                if (sweep_reg && !(sweep_end && pass_end))
                begin
                    st_next = ST_PINV;
                    t_load = 1'b1;
                    t_count = 24'(INV_CYC);
                end
                else
                    st_next = ST_IDLE;
            default:
                st_next = ST_IDLE;
        endcase
    end
    // ==========================================================
    // registers and pin drive
    // ==========================================================
    always_ff @(posedge i_mclk or negedge rstn)
        if (!rstn)
        begin
            st_reg <= ST_IDLE;
            adr_reg <= uvep_pkg::ADDR_RST;
            pass_reg <= 6'h00;
            sweep_reg <= 1'b0;
            gate_mode_reg <= 1'b0;
            o_addr_pin <= uvep_pkg::ADDR_RST;
            o_data_pin <= uvep_pkg::DATA_RST;
            o_data_oe_n <= 8'hFF;
            o_cs_n <= 1'b1;
            o_gate_neg <= 1'b0;
            o_drain_neg <= 1'b0;
            o_pgm_pulse <= 1'b0;
            o_busy <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rdata <= 8'h00;
            o_pgm_done <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            o_busy <= (st_next != ST_IDLE);
            o_rd_valid <= (st_reg == ST_RDONE);
            o_pgm_done <= (st_reg == ST_PNEXT) && (st_next == ST_IDLE);
            if (st_reg == ST_IDLE && i_rd_req)
            begin
                gate_mode_reg <= i_gate_pulse;
                adr_reg <= i_addr;
                o_cs_n <= 1'b0;
                o_gate_neg <= 1'b1;
            end
            else if (st_reg == ST_IDLE && i_pgm_req)
            begin
                // all-ones address with zero data runs the full sweep from zero
                sweep_reg <= sweep_req;
                adr_reg <= start_adr;
                pass_reg <= 6'h00;
            end
            if (st_reg == ST_RGATE && t_done)
                o_addr_pin <= adr_reg;
            if (st_reg == ST_RDONE)
            begin
                o_rdata <= din_reg;
                // device holds the byte after the gate rises
                if (gate_mode_reg)
                    o_gate_neg <= 1'b0;
                o_cs_n <= 1'b1;
            end
            if (st_reg == ST_RDESEL && t_done)
                o_gate_neg <= 1'b0;
            if (st_next == ST_PINV && st_reg != ST_PINV)
            begin
                o_addr_pin <= inv_adr;
                // low level writes a one, all bits together
                o_data_pin <= pgm_dat;
                o_data_oe_n <= 8'h00;
                o_cs_n <= 1'b0;
            end
            if (st_reg == ST_PINV && t_done)
            begin
                o_gate_neg <= 1'b1;
                o_drain_neg <= 1'b1;
            end
            if (st_reg == ST_PSUP && t_done)
                o_addr_pin <= adr_reg;
            o_pgm_pulse <= (st_next == ST_PPULSE);
            if (st_reg == ST_PHOLD && t_done)
            begin
                o_gate_neg <= 1'b0;
                o_drain_neg <= 1'b0;
                o_data_oe_n <= 8'hFF;
                o_data_pin <= uvep_pkg::DATA_RST;
                o_cs_n <= 1'b1;
            end
            if (st_reg == ST_PNEXT && sweep_reg)
            begin
                adr_reg <= adr_reg + 8'h01;
                if (sweep_end)
                    pass_reg <= pass_reg + 6'h01;
            end
        end
endmodule : uvep_host

// [dv/uvep_host_checker.sv]
`timescale 1ns/1ps
// ==================
// host pin sequencing checks
module uvep_host_checker #(
    parameter int INV_CYC = 4,
    parameter int TRUE_CYC = 4
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_rd_req,
    input wire logic i_pgm_req,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_addr_pin,
    input wire logic [7:0] o_data_pin,
    input wire logic [7:0] o_data_oe_n,
    input wire logic o_cs_n,
    input wire logic o_gate_neg,
    input wire logic o_drain_neg,
    input wire logic o_pgm_pulse,
    input wire logic o_busy
);
    logic [15:0] gate_reg = 16'h0000; // cycles gate negative
    logic [15:0] stab_reg = 16'h0000; // cycles address steady
    logic [7:0] prev_reg = 8'h00; // address last cycle
    logic [7:0] inv_reg = 8'h00; // address as supplies fell
    wire logic sweep = i_addr == 8'hFF && i_wdata == 8'h00;
    // saturating, so a long pulse never wraps a count
    always_ff @(posedge i_mclk)
    begin
        gate_reg <= o_gate_neg ? gate_reg + 16'(gate_reg != 16'hFFFF)
            : 16'h0000;
        stab_reg <= (o_addr_pin != prev_reg) ? 16'h0001
            : stab_reg + 16'(stab_reg != 16'hFFFF);
        prev_reg <= o_addr_pin;
        if ($rose(o_drain_neg)) inv_reg <= o_addr_pin;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // data must outlast the pulse by the hold time; checked for two cycles only
    sequence s_data_hold;
        (o_drain_neg && o_data_oe_n == 8'h00) [*2];
    endsequence
    chk_read_start: assert property (
        i_rd_req && !o_busy |=> o_busy && !o_cs_n && o_gate_neg)
        else $error("read start without select and gate");
    chk_pgm_start: assert property (
        i_pgm_req && !i_rd_req && !o_busy && !sweep |=> o_data_oe_n == 0
        && o_addr_pin == ~$past(i_addr) && o_data_pin == ~$past(i_wdata))
        else $error("program start not inverted");
    chk_gate_setup: assert property (
        !o_cs_n && o_data_oe_n == 8'hFF && $changed(o_addr_pin)
        |-> gate_reg >= uvep_pkg::GATE_SETUP_CYC)
        else $error("address before gate setup");
    chk_gate_release: assert property (
        $fell(o_gate_neg) && !$past(o_drain_neg)
        |-> stab_reg >= uvep_pkg::ACCESS_CYC)
        else $error("gate raised before access time");
    chk_inv_setup: assert property (
        $rose(o_drain_neg) |-> o_gate_neg && stab_reg >= INV_CYC)
        else $error("inverted address setup short");
    chk_true_addr: assert property (
        $rose(o_pgm_pulse) |-> o_addr_pin == ~inv_reg && stab_reg >= TRUE_CYC)
        else $error("true address setup wrong");
    chk_pulse_supply: assert property (
        o_pgm_pulse |-> o_drain_neg && o_gate_neg && o_data_oe_n == 8'h00)
        else $error("pulse outside negative supplies");
    chk_data_hold: assert property (
        $fell(o_pgm_pulse) |-> s_data_hold)
        else $error("data released at pulse end");
    chk_idle_quiet: assert property (
        !o_busy |-> o_cs_n && !o_drain_neg && o_data_oe_n == 8'hFF)
        else $error("lines active while idle");
endmodule : uvep_host_checker
bind uvep_host uvep_host_checker #(.INV_CYC(INV_CYC), .TRUE_CYC(TRUE_CYC))
    u_chk (.i_mclk, .i_resetn, .i_rd_req, .i_pgm_req, .i_addr, .i_wdata,
    .o_addr_pin, .o_data_pin, .o_data_oe_n, .o_cs_n, .o_gate_neg,
    .o_drain_neg, .o_pgm_pulse, .o_busy);

// [dv/uvep_dev_model.sv]
`timescale 1ns/1ps
// ==================
// behavioural 256 x 8 device
module uvep_dev_model (
    input wire logic [7:0] i_addr_pin,
    input wire logic [7:0] i_host_data,
    input wire logic [7:0] i_host_oe_n,
    input wire logic i_cs_n,
    input wire logic i_gate_neg,
    input wire logic i_drain_neg,
    input wire logic i_pgm_pulse,
    output logic [7:0] o_pin,
    output int o_pulses,
    output int o_in_order
);
    logic [7:0] mem [256];
    logic [7:0] dout = 8'h00; // output stage
    logic [7:0] last_reg = 8'h00; // address of previous pulse
    logic drv = 1'b0; // device drives the lines
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        o_pulses = 0;
        o_in_order = 0;
    end
    // junk at once, byte after access; gate high holds it
    always @(i_addr_pin or i_cs_n or i_gate_neg)
    begin
        if (!i_cs_n && i_gate_neg && !i_drain_neg)
        begin
            dout <= ~dout;
            dout <= #(uvep_pkg::ACCESS_NS - 20) mem[i_addr_pin];
        end
    end
    always @(i_cs_n) drv <= #(uvep_pkg::DESELECT_NS) !i_cs_n;
    // released lines show the inverse, never a helpful value
    assign o_pin = (i_host_data & ~i_host_oe_n)
        | ((drv ? dout : ~dout) & i_host_oe_n);
    // all eight bits at one pulse; low line sets a one
    always @(posedge i_pgm_pulse)
    begin
        if (i_drain_neg && i_gate_neg)
        begin
            mem[i_addr_pin] <= mem[i_addr_pin] | ~o_pin;
            o_pulses <= o_pulses + 1;
            o_in_order <= o_in_order + int'(i_addr_pin == last_reg + 8'h01);
            last_reg <= i_addr_pin;
        end
    end
endmodule : uvep_dev_model

// [dv/tb_uv_eprom_read_program_port.sv]
`timescale 1ns/1ps
// ==================
// host controller against the device model
module tb_uv_eprom_read_program_port;
    localparam int PASSES = 2; // short sweep
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_rd_req = 1'b0;
    logic i_pgm_req = 1'b0;
    logic i_gate_pulse = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] rd_seen; // byte caught at the read strobe
    wire logic [7:0] i_data_pin, o_addr_pin, o_data_pin, o_data_oe_n, o_rdata;
    wire logic o_cs_n, o_gate_neg, o_drain_neg, o_pgm_pulse;
    wire logic o_busy, o_rd_valid, o_pgm_done;
    int pulses, in_order;
    int fail_count = 0;
    int n_compared = 0;
    // small counts keep the sweep short
    uvep_host #(.PULSE_CYC(4), .SUPPLY_CYC(4), .INV_CYC(4), .TRUE_CYC(4),
        .HOLD_CYC(4), .PASSES(PASSES)) dut (.i_mclk, .i_resetn, .i_rd_req,
        .i_pgm_req, .i_gate_pulse, .i_addr, .i_wdata, .i_data_pin,
        .o_addr_pin, .o_data_pin, .o_data_oe_n, .o_cs_n, .o_gate_neg,
        .o_drain_neg, .o_pgm_pulse, .o_busy, .o_rd_valid, .o_rdata,
        .o_pgm_done);
    uvep_dev_model u_dev (.i_addr_pin(o_addr_pin), .i_host_data(o_data_pin),
        .i_host_oe_n(o_data_oe_n), .i_cs_n(o_cs_n), .i_gate_neg(o_gate_neg),
        .i_drain_neg(o_drain_neg), .i_pgm_pulse(o_pgm_pulse),
        .o_pin(i_data_pin), .o_pulses(pulses), .o_in_order(in_order));
    initial forever #2 i_mclk = ~i_mclk;
    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one request, then wait for busy to fall, bounded
    task automatic xfer(input logic pgm, input logic [7:0] a,
        input logic [7:0] w, input logic gp);
        int n;
        int n_done;
        n = 0;
        n_done = 0;
        rd_seen = 8'hxx;
        @(posedge i_mclk);
        i_rd_req <= !pgm;
        i_pgm_req <= pgm;
        i_addr <= a;
        i_wdata <= w;
        i_gate_pulse <= gp;
        @(posedge i_mclk);
        i_rd_req <= 1'b0;
        i_pgm_req <= 1'b0;
        #1;
        while (o_busy !== 1'b0 && n < 20000)
        begin
            if (o_rd_valid === 1'b1) rd_seen = o_rdata;
            @(posedge i_mclk);
            #1;
            n++;
            if (o_pgm_done === 1'b1) n_done++;
        end
        if (n >= 20000)
        begin
            fail_count++;
            $display("ERROR busy expected 0 seen %b", o_busy);
        end
        check("pgm_done", {7'h00, pgm}, 8'(n_done));
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic gp,
        input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, gp);
        check("rdata", exp, rd_seen);
        check("cs_n", 8'h01, {7'h00, o_cs_n});
    endtask : rd_chk
    task automatic t_program;
        int p0;
        p0 = pulses;
        rd_chk(8'h5A, 1'b0, 8'h00);
        xfer(1'b1, 8'h3C, 8'hA5, 1'b0);
        check("pulses", 8'h01, 8'(pulses - p0));
        rd_chk(8'h3C, 1'b0, 8'hA5);
        xfer(1'b1, 8'h3C, 8'h0F, 1'b0);
        rd_chk(8'h3C, 1'b1, 8'hAF);
        rd_chk(8'h3D, 1'b1, 8'h00);
        $display("test program done");
    endtask : t_program
    task automatic t_bounds;
        xfer(1'b1, 8'h00, 8'h81, 1'b0);
        xfer(1'b1, 8'hFE, 8'h7E, 1'b0);
        rd_chk(8'h00, 1'b0, 8'h81);
        rd_chk(8'hFE, 1'b1, 8'h7E);
        $display("test bounds done");
    endtask : t_bounds
    task automatic t_sweep;
        int p0;
        int q0;
        p0 = pulses;
        q0 = in_order;
        xfer(1'b1, 8'hFF, 8'h00, 1'b0);
        check("pulses", 8'h00, 8'(pulses - p0 - 256 * PASSES));
        check("order", 8'h00, 8'(in_order - q0 - 256 * PASSES + 1));
        rd_chk(8'hFF, 1'b0, 8'hFF);
        rd_chk(8'h5A, 1'b1, 8'hFF);
        $display("test sweep done");
    endtask : t_sweep
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        t_program();
        t_bounds();
        t_sweep();
        results();
    end
    // cut a hang short
    initial
    begin
        repeat (40000) @(posedge i_mclk);
        fail_count++;
        results();
    end
endmodule : tb_uv_eprom_read_program_port
